// ---- host_master.sv ----
// Host bus master model
`timescale 1ns/1ns
module host_master(input wire clk_sys_in, output reg [21:0] addr_in,
  output reg [15:0] data_lines_in, output reg addr_strobe_in, reply_in,
  word_or_byte_write_cycle_in, read_cycle_in, write_strobe_in, data_in_strobe_in);
  initial {addr_in, data_lines_in, addr_strobe_in, reply_in, word_or_byte_write_cycle_in,
    read_cycle_in, write_strobe_in, data_in_strobe_in} = 44'h0;
  task xfer(input [21:0] a, input w, input [15:0] d);
    begin
      @(posedge clk_sys_in);
      {addr_in, data_lines_in, addr_strobe_in, data_in_strobe_in} <= {a, d, 2'h2};
      {word_or_byte_write_cycle_in, read_cycle_in} <= {w, !w};
      @(posedge clk_sys_in);
      addr_strobe_in <= 1'b0;
      @(posedge clk_sys_in);
      {write_strobe_in, reply_in} <= {w, !w};
      @(posedge clk_sys_in);
      {write_strobe_in, reply_in, data_in_strobe_in} <= {2'h0, !w};
      #1;
    end
  endtask
endmodule

// ---- parity_csr_checker.sv ----
// Checker for the parity and status register block
`timescale 1ns/1ns
module parity_csr_checker(input wire clk_sys_in, arst_n_in, bus_init_in,
  refresh_cycle_in, read_in_gate_in, data_in_strobe_in, reg_selected_out,
  row_col_strobe_inhibit_out, parity_error_detect_out, capture_strobe_out,
  error_flag_line_lo_out, error_flag_line_hi_out, reg_read_drive_out,
  error_lamp_out, input wire [15:0] reg_read_data_out);
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!arst_n_in);
  sequence lamp_lit;
    ##1 error_lamp_out;
  endsequence
  AST_CAP:
  assert property (capture_strobe_out |-> parity_error_detect_out) else $error("bad capture");
  AST_LAMP:
  assert property (capture_strobe_out && !bus_init_in |-> lamp_lit) else $error("lamp off");
  AST_FLAG:
  assert property (error_flag_line_lo_out |-> $past(parity_error_detect_out)
    && !$past(read_in_gate_in)) else $error("bad flag");
  AST_PAIR:
  assert property (error_flag_line_lo_out == error_flag_line_hi_out) else $error("flags split");
  AST_ZERO:
  assert property ((reg_read_data_out & 16'h301a) == 16'h0) else $error("unused bit set");
  AST_INH:
  assert property (reg_selected_out || refresh_cycle_in |-> !parity_error_detect_out)
    else $error("check not inhibited");
  AST_ROW:
  assert property (row_col_strobe_inhibit_out == reg_selected_out) else $error("strobes on");
  AST_DRV:
  assert property (reg_read_drive_out |-> data_in_strobe_in && reg_selected_out)
    else $error("bad drive");
endmodule
bind parity_error_csr parity_csr_checker parity_csr_checker_inst(.*);

// ---- parity_csr_regs.vh ----
// Constants for the byte-parity logic and its control and status register
// What this block does
// - Write stores odd parity for low byte
// - Write stores even parity for high byte
// - Generate on writes, check on reads
// - Wrong-parity bit corrupts stored parity bits
// - Read expects byte0 even, byte1 odd
// - Report needs enable, error, read gate negated
// - Enabled error drives both flag lines
// - Enable bit read/write, cleared by init
// - Latched read error makes capture strobe
// - Capture A11-A17 to 5-11, latch A18-A21
// - Bit 14 selects upper address on read
// - Address bits read/write, survive init
// - Newest error overwrites captured address
// - Bits 1,3,4,12,13 read zero
// - Wrong-parity bit read/write, cleared by init
// - Bit 15 set on error, drives lamp
// - Bit 15 read/write, init clears, sticky
// - Register and refresh cycles inhibit parity
// - Register select on address match; strobes suppressed
// - Register read latched at reply, driven on data-in strobe
`ifndef PARITY_CSR_REGS_VH
`define PARITY_CSR_REGS_VH
`define BIT_PAR_EN 0
`define BIT_WRONG_PAR 2
`define BIT_ADDR_LO 5
`define BIT_ADDR_HI 11
`define BIT_EXT_RD 14
`define BIT_PAR_ERR 15
`define ADDR_LO_W 7
`define ADDR_UP_W 4
`define FLD_A_LO_LSB 11
`define FLD_A_LO_MSB 17
`define FLD_A_UP_LSB 18
`define FLD_A_UP_MSB 21
`define SEL_LSB 1
`define SEL_MSB 4
`endif

// ---- parity_error_csr.v ----
// Byte-parity generate/check logic with its control and status register
`timescale 1ns/1ns
`include "parity_csr_regs.vh"
module parity_error_csr
(
  input wire clk_sys_in,
  input wire arst_n_in,
  input wire bus_init_in,
  input wire [21:0] addr_in,
  input wire [3:0] reg_select_jumpers_in,
  input wire addr_strobe_in,
  input wire word_or_byte_write_cycle_in,
  input wire read_cycle_in,
  input wire read_modify_write_cycle_in,
  input wire refresh_cycle_in,
  input wire write_strobe_in,
  input wire [15:0] data_lines_in,
  input wire read_data_latch_in,
  input wire [15:0] mem_data_in,
  input wire low_byte_parity_bit_in,
  input wire high_byte_parity_bit_in,
  input wire read_in_gate_in,
  input wire reply_in,
  input wire data_in_strobe_in,
  output wire reg_selected_out,
  output wire row_col_strobe_inhibit_out,
  output reg low_byte_parity_bit_out,
  output reg high_byte_parity_bit_out,
  output wire parity_store_out,
  output wire parity_error_detect_out,
  output wire capture_strobe_out,
  output reg error_flag_line_lo_out,
  output reg error_flag_line_hi_out,
  output reg [15:0] reg_read_data_out,
  output wire reg_read_drive_out,
  output wire error_lamp_out
);

  reg sel_q;
  reg [21:0] lat_addr_q;
  reg par_en_q;
  reg wrong_par_q;
  reg ext_rd_q;
  reg par_err_q;
  reg [`ADDR_LO_W-1:0] addr_lo_q;
  reg [`ADDR_UP_W-1:0] addr_up_q;
  reg [15:0] csr_view;
  wire sel_match;
  wire mem_access;
  wire wr_cycle;
  wire rd_cycle;
  wire gen_lo;
  wire gen_hi;
  wire par_ok_lo;
  wire par_ok_hi;
  wire err_raw;
  wire report;
  wire reg_wr;
  wire capture;

  // Register select by address match
  assign sel_match = (addr_in[`SEL_MSB:`SEL_LSB] == reg_select_jumpers_in);

  // Select latched at address strobe
  always @(posedge clk_sys_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      sel_q <= 1'h0;
    end
    else if (addr_strobe_in)
    begin
      sel_q <= sel_match;
    end
  end

  // Access address kept for capture
  always @(posedge clk_sys_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      lat_addr_q <= 22'h000000;
    end
    else if (addr_strobe_in)
    begin
      lat_addr_q <= addr_in;
    end
  end

  assign reg_selected_out = sel_q;

  assign row_col_strobe_inhibit_out = sel_q;

  assign mem_access = !sel_q && !refresh_cycle_in;

  assign wr_cycle = word_or_byte_write_cycle_in && write_strobe_in;
  assign rd_cycle = read_cycle_in || read_modify_write_cycle_in;

  assign gen_lo = ~(^data_lines_in[7:0]);

  assign gen_hi = ^data_lines_in[15:8];

  always @(posedge clk_sys_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      low_byte_parity_bit_out <= 1'h0;
    end
    else
    begin
      low_byte_parity_bit_out <= gen_lo ^ wrong_par_q;
    end
  end

  always @(posedge clk_sys_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      high_byte_parity_bit_out <= 1'h0;
    end
    else
    begin
      high_byte_parity_bit_out <= gen_hi ^ wrong_par_q;
    end
  end

  // store parity on memory writes only
  assign parity_store_out = wr_cycle && mem_access;

  // byte 0 even, byte 1 odd
  assign par_ok_lo = ~(^{low_byte_parity_bit_in, mem_data_in[7:0]});
  assign par_ok_hi = ^{high_byte_parity_bit_in, mem_data_in[15:8]};

  assign err_raw = mem_access && rd_cycle && !(par_ok_lo && par_ok_hi);
  assign parity_error_detect_out = err_raw;

  assign capture = err_raw && read_data_latch_in;
  assign capture_strobe_out = capture;

  assign report = par_en_q && err_raw && !read_in_gate_in;

  always @(posedge clk_sys_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      error_flag_line_lo_out <= 1'h0;
    end
    else
    begin
      error_flag_line_lo_out <= report;
    end
  end

  always @(posedge clk_sys_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      error_flag_line_hi_out <= 1'h0;
    end
    else
    begin
      error_flag_line_hi_out <= report;
    end
  end

  assign reg_wr = sel_q && wr_cycle;

  always @(posedge clk_sys_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      par_en_q <= 1'h0;
    end
    else if (bus_init_in)
    begin
      par_en_q <= 1'h0;
    end
    else if (reg_wr)
    begin
      par_en_q <= data_lines_in[`BIT_PAR_EN];
    end
  end

  always @(posedge clk_sys_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      wrong_par_q <= 1'h0;
    end
    else if (bus_init_in)
    begin
      wrong_par_q <= 1'h0;
    end
    else if (reg_wr)
    begin
      wrong_par_q <= data_lines_in[`BIT_WRONG_PAR];
    end
  end

  always @(posedge clk_sys_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      ext_rd_q <= 1'h0;
    end
    else if (bus_init_in)
    begin
      ext_rd_q <= 1'h0;
    end
    else if (reg_wr)
    begin
      ext_rd_q <= data_lines_in[`BIT_EXT_RD];
    end
  end

  always @(posedge clk_sys_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      par_err_q <= 1'h0;
    end
    else if (bus_init_in)
    begin
      par_err_q <= 1'h0;
    end
    else if (capture)
    begin
      par_err_q <= 1'h1;
    end
    else if (reg_wr)
    begin
      par_err_q <= data_lines_in[`BIT_PAR_ERR];
    end
  end

  always @(posedge clk_sys_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      addr_lo_q <= 7'h00;
    end
    else if (capture)
    begin
      addr_lo_q <= lat_addr_q[`FLD_A_LO_MSB:`FLD_A_LO_LSB];
    end
    else if (reg_wr && !ext_rd_q)
    begin
      addr_lo_q <= data_lines_in[`BIT_ADDR_HI:`BIT_ADDR_LO];
    end
  end

  always @(posedge clk_sys_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      addr_up_q <= 4'h0;
    end
    else if (capture)
    begin
      addr_up_q <= lat_addr_q[`FLD_A_UP_MSB:`FLD_A_UP_LSB];
    end
    else if (reg_wr && ext_rd_q)
    begin
      addr_up_q <= data_lines_in[`BIT_ADDR_LO+`ADDR_UP_W-1:`BIT_ADDR_LO];
    end
  end

  always @*
  begin
    csr_view = 16'h0000;
    csr_view[`BIT_PAR_EN] = par_en_q;
    csr_view[`BIT_WRONG_PAR] = wrong_par_q;
    csr_view[`BIT_EXT_RD] = ext_rd_q;
    csr_view[`BIT_PAR_ERR] = par_err_q;
    if (ext_rd_q)
    begin
      csr_view[`BIT_ADDR_LO+`ADDR_UP_W-1:`BIT_ADDR_LO] = addr_up_q;
    end
    else
    begin
      csr_view[`BIT_ADDR_HI:`BIT_ADDR_LO] = addr_lo_q;
    end
  end

  always @(posedge clk_sys_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      reg_read_data_out <= 16'h0000;
    end
    else if (sel_q && reply_in)
    begin
      reg_read_data_out <= csr_view;
    end
  end

  assign reg_read_drive_out = sel_q && data_in_strobe_in;

  assign error_lamp_out = par_err_q;

endmodule

// ---- tb_top.sv ----
// Bench for the parity and status register block
`timescale 1ns/1ns
module tb_top;
  logic clk_sys_in = 0, arst_n_in = 0, bus_init_in = 0, refresh_cycle_in = 0;
  logic read_modify_write_cycle_in = 0, read_data_latch_in = 0, read_in_gate_in = 0;
  logic low_byte_parity_bit_in = 0, high_byte_parity_bit_in = 0, addr_strobe_in, reply_in;
  logic word_or_byte_write_cycle_in, read_cycle_in, write_strobe_in, data_in_strobe_in;
  logic reg_selected_out, row_col_strobe_inhibit_out, parity_store_out, error_lamp_out;
  logic low_byte_parity_bit_out, high_byte_parity_bit_out, parity_error_detect_out;
  logic capture_strobe_out, error_flag_line_lo_out, error_flag_line_hi_out, reg_read_drive_out;
  logic [3:0] reg_select_jumpers_in = 4'ha, up = 4'h0;
  logic [6:0] lo = 7'h0;
  logic [15:0] mem_data_in = 16'h0, data_lines_in, reg_read_data_out, ctl = 16'h0, md, d;
  logic [21:0] addr_in, a, ra = 22'h14;
  int errors = 0, n_checks = 0, seed = 71298, i;
  parity_error_csr parity_error_csr_inst(.*);
  host_master host_master_inst(.*);
  always #2 clk_sys_in = !clk_sys_in;
  task chk(input string n, input logic [15:0] e, g);
    begin
      n_checks++;
      if (g !== e)
      begin
        errors++;
        $display("[ERR] %s exp %h got %h", n, e, g);
      end
    end
  endtask
  task rr;
    begin
      host_master_inst.xfer(ra, 1'b0, 16'h0);
      chk("csr", ctl & 16'hc005 | ((ctl[14] ? up : lo) << 5), reg_read_data_out);
    end
  endtask
  task rw(input logic [15:0] v);
    begin
      host_master_inst.xfer(ra, 1'b1, v);
      if (ctl[14]) up = v[8:5];
      else lo = v[11:5];
      ctl = v & 16'hc005;
    end
  endtask
  task mr(input logic b, g, r);
    begin
      md = $random(seed);
      a = {md[3:0], md[6:4], md[3:0], 11'h0};
      @(posedge clk_sys_in);
      {mem_data_in, read_in_gate_in, refresh_cycle_in, read_modify_write_cycle_in} <= {md, g, r, g};
      {low_byte_parity_bit_in, high_byte_parity_bit_in} <= {^md[7:0] ^ b, ~^md[15:8]};
      host_master_inst.xfer(a, 1'b0, 16'h0);
      @(posedge clk_sys_in);
      read_data_latch_in <= 1'b1;
      @(posedge clk_sys_in);
      {read_data_latch_in, read_in_gate_in, refresh_cycle_in, read_modify_write_cycle_in} <= 4'h0;
      low_byte_parity_bit_in <= ^md[7:0];
      #1 chk("flags", {2{b & !g & !r}}, {error_flag_line_hi_out, error_flag_line_lo_out});
      if (b & !r) {ctl[15], up, lo} = {1'b1, a[21:11]};
    end
  endtask
  task test_done;
    begin
      $display("checks %0d errors %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0)
        $display("All tests passed");
      else
        $display("Some tests failed");
      $finish;
    end
  endtask
  initial
  begin
    #20000;
    errors++;
    test_done;
  end
  initial
  begin
    repeat (4) @(posedge clk_sys_in);
    arst_n_in <= 1'b1;
    rr;
    rw(16'hbfff);
    rr;
    @(posedge clk_sys_in);
    bus_init_in <= 1'b1;
    @(posedge clk_sys_in);
    bus_init_in <= 1'b0;
    ctl = 16'h0;
    rr;
    for (i = 0; i < 6; i++)
    begin
      if (i % 3 == 0) rw(i ? 16'h0001 : 16'h0005);
      d = $random(seed);
      host_master_inst.xfer({d, 6'h0}, 1'b1, d);
      chk("par", {^d[15:8], ~^d[7:0]} ^ {2{ctl[2]}},
        {high_byte_parity_bit_out, low_byte_parity_bit_out});
    end
    for (i = 0; i < 4; i++)
    begin
      mr(i != 3, i == 1, i == 2);
      rr;
    end
    rw(16'h4001 | lo << 5);
    rr;
    test_done;
  end
endmodule
